// file: rtl/usbrrc_regs.svh
// Register offsets, bit positions and timing counts for reset/run control
`ifndef USBRRC_REGS_SVH
`define USBRRC_REGS_SVH

`define USBRRC_ADDR_W 5
`define USBRRC_CMD_OFS 5'h00
`define USBRRC_STS_OFS 5'h02
`define USBRRC_PORT0_OFS 5'h10
`define USBRRC_PORT1_OFS 5'h12

`define USBRRC_CMD_RUN 0
`define USBRRC_CMD_SRST 1
`define USBRRC_CMD_GRST 2

`define USBRRC_STS_SYSERR 3
`define USBRRC_STS_PROCERR 4
`define USBRRC_STS_HALTED 5

`define USBRRC_PSC_CONN 0
`define USBRRC_PSC_CCHG 1
`define USBRRC_PSC_EN 2
`define USBRRC_PSC_ECHG 3
`define USBRRC_PSC_LS 8
`define USBRRC_PSC_PRST 9

`define USBRRC_CLK_PS 4000
`define USBRRC_BIT_TIME_PS 83333
`define USBRRC_DETECT_BITS 64
`define USBRRC_GRST_MIN_MS 10
`define USBRRC_HCR_CYCLES 4

`endif

// file: rtl/usbrrc_pkg.sv
// Shared types for the reset and run control block
package usbrrc_pkg;

	typedef enum logic [2:0] {
		SCH_HALT = 3'b001,
		SCH_IDLE = 3'b010,
		SCH_BUSY = 3'b100
	} usbrrc_sched_t;

	typedef enum logic [2:0] {
		PC_RESET = 3'b001,
		PC_DETECT = 3'b010,
		PC_TRACK = 3'b100
	} usbrrc_conn_t;

	typedef struct packed {
		logic low_speed;
		logic en_chg;
		logic enabled;
		logic conn_chg;
		logic connected;
	} usbrrc_port_sts_t;

	typedef struct packed {
		logic wr;
		logic [15:0] data;
	} usbrrc_io_wr_t;

endpackage

// file: rtl/usbrrc_sched.sv
// Schedule run/stop engine: starts transactions while running, halts cleanly
`timescale 1ns/1ps
module usbrrc_sched (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic txn_done_i,
	output logic txn_start_o,
	output logic busy_o,
	output logic halted_o
);

	usbrrc_pkg::usbrrc_sched_t state_q;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_q <= usbrrc_pkg::SCH_HALT;
		end else begin
			unique case (state_q)
				usbrrc_pkg::SCH_HALT: begin
					if (run_i) begin
						state_q <= usbrrc_pkg::SCH_IDLE;
					end
				end
				usbrrc_pkg::SCH_IDLE: begin
					if (run_i) begin
						state_q <= usbrrc_pkg::SCH_BUSY;
					end else begin
						state_q <= usbrrc_pkg::SCH_HALT;
					end
				end
				usbrrc_pkg::SCH_BUSY: begin
					// Current transaction runs to its end; only a reset on rst_i leaves this state early
					if (txn_done_i) begin
						state_q <= run_i ? usbrrc_pkg::SCH_IDLE : usbrrc_pkg::SCH_HALT;
					end
				end
			endcase
		end
	end

	assign txn_start_o = (state_q == usbrrc_pkg::SCH_IDLE) && run_i;
	assign busy_o = (state_q == usbrrc_pkg::SCH_BUSY);
	assign halted_o = (state_q == usbrrc_pkg::SCH_HALT);

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	no_start_stopped_a: assert property (!run_i |-> !txn_start_o)
		else $error("transaction started while stopped");
	busy_holds_a: assert property ((busy_o && !txn_done_i) |=> busy_o)
		else $error("transaction dropped before done");
	halt_after_stop_a: assert property ((busy_o && txn_done_i && !run_i) |=> halted_o)
		else $error("halted flag not set after last transaction");

endmodule

// file: rtl/usbrrc_port.sv
// Root port connect/disconnect machine and its status/control bits
`timescale 1ns/1ps
`include "usbrrc_regs.svh"
module usbrrc_port (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic soft_rst_i,
	input wire usbrrc_pkg::usbrrc_io_wr_t wr_i,
	input wire logic present_i,
	input wire logic low_speed_i,
	output usbrrc_pkg::usbrrc_port_sts_t sts_o,
	output logic port_reset_o,
	output logic connect_o
);

	localparam int DetCycles = (`USBRRC_DETECT_BITS * `USBRRC_BIT_TIME_PS
		+ `USBRRC_CLK_PS - 1) / `USBRRC_CLK_PS;

	usbrrc_pkg::usbrrc_conn_t state_q;
	logic [10:0] cnt_q;
	logic pres_s1_q, pres_s2_q, ls_s1_q, ls_s2_q;
	logic conn_d, wr_en;
	usbrrc_pkg::usbrrc_port_sts_t sts_q;
	logic prst_q;

	always_ff @(posedge ref_clk_i) begin
		pres_s1_q <= present_i;
		pres_s2_q <= pres_s1_q;
		ls_s1_q <= low_speed_i;
		ls_s2_q <= ls_s1_q;
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i || soft_rst_i) begin
			state_q <= usbrrc_pkg::PC_RESET;
			cnt_q <= 11'h000;
		end else begin
			unique case (state_q)
				usbrrc_pkg::PC_RESET: begin
					state_q <= usbrrc_pkg::PC_DETECT;
				end
				usbrrc_pkg::PC_DETECT: begin
					if (cnt_q == 11'(DetCycles - 1)) begin
						state_q <= usbrrc_pkg::PC_TRACK;
					end else begin
						cnt_q <= cnt_q + 11'h001;
					end
				end
				usbrrc_pkg::PC_TRACK: begin
					state_q <= usbrrc_pkg::PC_TRACK;
				end
			endcase
		end
	end

	assign conn_d = (state_q == usbrrc_pkg::PC_TRACK) && pres_s2_q;
	assign wr_en = wr_i.wr;

	// Only bits 8 and 3:0 see the soft reset; bit 9 is left alone
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sts_q <= '0;
		end else if (soft_rst_i) begin
			sts_q.connected <= 1'b0;
			sts_q.conn_chg <= 1'b1;
			sts_q.enabled <= 1'b0;
			sts_q.en_chg <= 1'b1;
			sts_q.low_speed <= 1'b0;
		end else begin
			sts_q.connected <= conn_d;
			if (conn_d && !sts_q.connected) begin
				sts_q.low_speed <= ls_s2_q;
			end else if (!conn_d) begin
				sts_q.low_speed <= 1'b0;
			end
			// Hardware set wins over a write-one clear in the same cycle
			if (conn_d != sts_q.connected) begin
				sts_q.conn_chg <= 1'b1;
			end else if (wr_en && wr_i.data[`USBRRC_PSC_CCHG]) begin
				sts_q.conn_chg <= 1'b0;
			end
			if (!conn_d) begin
				sts_q.enabled <= 1'b0;
			end else if (wr_en) begin
				sts_q.enabled <= wr_i.data[`USBRRC_PSC_EN];
			end
			if (!conn_d && sts_q.enabled) begin
				sts_q.en_chg <= 1'b1;
			end else if (wr_en && wr_i.data[`USBRRC_PSC_ECHG]) begin
				sts_q.en_chg <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			prst_q <= 1'b0;
		end else if (wr_en) begin
			prst_q <= wr_i.data[`USBRRC_PSC_PRST];
		end
	end

	assign sts_o = sts_q;
	assign port_reset_o = prst_q;
	assign connect_o = sts_q.connected;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	soft_virt_disc_a: assert property (soft_rst_i |=> (sts_q.conn_chg && sts_q.en_chg
		&& !sts_q.connected && !sts_q.low_speed))
		else $error("soft reset did not raise disconnect changes");
	soft_keeps_prst_a: assert property ((soft_rst_i && !wr_en) |=> $stable(prst_q))
		else $error("soft reset disturbed an unrelated port bit");
	detect_delay_a: assert property ($fell(soft_rst_i) |-> !connect_o [*8])
		else $error("connect reported before detection delay");

endmodule

// file: rtl/usbrrc_top.sv
// Host command low bits: bus-wide reset, soft reset and schedule run control
`timescale 1ns/1ps
`include "usbrrc_regs.svh"
module usbrrc_top (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [`USBRRC_ADDR_W-1:0] io_addr_i,
	input wire logic [15:0] io_wdata_i,
	output logic [15:0] io_rdata_o,
	output logic bus_reset_o,
	output logic txn_start_o,
	output logic txn_abort_o,
	input wire logic txn_done_i,
	input wire logic fatal_consist_i,
	input wire logic fatal_bus_err_i,
	input wire logic [1:0] dev_present_i,
	input wire logic [1:0] dev_low_speed_i,
	output logic [1:0] port_connect_o,
	output logic [1:0] port_enable_o,
	output logic [1:0] port_reset_o
);

	localparam int HcrCycles = `USBRRC_HCR_CYCLES;
	localparam logic [2:0] HcrLast = 3'(`USBRRC_HCR_CYCLES - 1);

	logic run_q, srst_q, grst_q;
	logic [2:0] srst_cnt_q;
	logic procerr_q, syserr_q;
	logic [15:0] rdata_q;

	logic hw_rst;
	logic logic_rst;
	logic wr_cmd, wr_sts;
	logic [1:0] wr_port;
	logic fatal;
	logic sched_busy, sched_halted;
	usbrrc_pkg::usbrrc_port_sts_t port_sts [2];
	logic [15:0] port_word [2];

	// Bus-wide reset clears everything except its own bit, the read data register and the port input synchronizers
	assign hw_rst = rst_i || grst_q;
	// Soft reset also clears the schedule engine, run bit and error flags; ports take srst_q directly
	assign logic_rst = hw_rst || srst_q;

	assign wr_cmd = io_wr_i && (io_addr_i == `USBRRC_CMD_OFS);
	assign wr_sts = io_wr_i && (io_addr_i == `USBRRC_STS_OFS);
	assign wr_port[0] = io_wr_i && (io_addr_i == `USBRRC_PORT0_OFS);
	assign wr_port[1] = io_wr_i && (io_addr_i == `USBRRC_PORT1_OFS);
	assign fatal = fatal_consist_i || fatal_bus_err_i;

	// Bus-wide reset bit: only chip reset or software clears it
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			grst_q <= 1'b0;
		end else if (wr_cmd) begin
			grst_q <= io_wdata_i[`USBRRC_CMD_GRST];
		end
	end

	// Held low by hardware reset even though internal state is the same
	assign bus_reset_o = grst_q && !rst_i;

	// Soft reset bit with self-clearing sequencer
	always_ff @(posedge ref_clk_i) begin
		if (hw_rst) begin
			srst_q <= 1'b0;
			srst_cnt_q <= 3'h0;
		end else if (srst_q) begin
			if (srst_cnt_q == HcrLast) begin
				srst_q <= 1'b0;
				srst_cnt_q <= 3'h0;
			end else begin
				srst_cnt_q <= srst_cnt_q + 3'h1;
			end
		end else if (wr_cmd && io_wdata_i[`USBRRC_CMD_SRST]) begin
			srst_q <= 1'b1;
		end
	end

	// Run bit: fatal error clear beats a software set in the same cycle
	always_ff @(posedge ref_clk_i) begin
		if (logic_rst) begin
			run_q <= 1'b0;
		end else if (fatal) begin
			run_q <= 1'b0;
		end else if (wr_cmd) begin
			run_q <= io_wdata_i[`USBRRC_CMD_RUN];
		end
	end

	// Error flags are write-one-to-clear; a new error wins over the clear
	always_ff @(posedge ref_clk_i) begin
		if (logic_rst) begin
			procerr_q <= 1'b0;
		end else if (fatal_consist_i) begin
			procerr_q <= 1'b1;
		end else if (wr_sts && io_wdata_i[`USBRRC_STS_PROCERR]) begin
			procerr_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (logic_rst) begin
			syserr_q <= 1'b0;
		end else if (fatal_bus_err_i) begin
			syserr_q <= 1'b1;
		end else if (wr_sts && io_wdata_i[`USBRRC_STS_SYSERR]) begin
			syserr_q <= 1'b0;
		end
	end

	usbrrc_sched u_sched (
		.ref_clk_i(ref_clk_i),
		.rst_i(logic_rst),
		.run_i(run_q),
		.txn_done_i(txn_done_i),
		.txn_start_o(txn_start_o),
		.busy_o(sched_busy),
		.halted_o(sched_halted)
	);

	// In-flight transaction is cut off rather than completed
	assign txn_abort_o = sched_busy && (srst_q || hw_rst);

	generate
		for (genvar p = 0; p < 2; p++) begin : g_port
			usbrrc_port u_port (
				.ref_clk_i(ref_clk_i),
				.rst_i(hw_rst),
				.soft_rst_i(srst_q),
				.wr_i('{wr: wr_port[p], data: io_wdata_i}),
				.present_i(dev_present_i[p]),
				.low_speed_i(dev_low_speed_i[p]),
				.sts_o(port_sts[p]),
				.port_reset_o(port_reset_o[p]),
				.connect_o(port_connect_o[p])
			);
			assign port_enable_o[p] = port_sts[p].enabled;
			always_comb begin
				port_word[p] = 16'h0000;
				port_word[p][`USBRRC_PSC_CONN] = port_sts[p].connected;
				port_word[p][`USBRRC_PSC_CCHG] = port_sts[p].conn_chg;
				port_word[p][`USBRRC_PSC_EN] = port_sts[p].enabled;
				port_word[p][`USBRRC_PSC_ECHG] = port_sts[p].en_chg;
				port_word[p][`USBRRC_PSC_LS] = port_sts[p].low_speed;
				port_word[p][`USBRRC_PSC_PRST] = port_reset_o[p];
			end
		end
	endgenerate

	// Read data registered; unmapped offsets read zero
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rdata_q <= 16'h0000;
		end else if (io_rd_i) begin
			rdata_q <= 16'h0000;
			unique case (io_addr_i)
				`USBRRC_CMD_OFS: begin
					rdata_q[`USBRRC_CMD_RUN] <= run_q;
					rdata_q[`USBRRC_CMD_SRST] <= srst_q;
					rdata_q[`USBRRC_CMD_GRST] <= grst_q;
				end
				`USBRRC_STS_OFS: begin
					rdata_q[`USBRRC_STS_SYSERR] <= syserr_q;
					rdata_q[`USBRRC_STS_PROCERR] <= procerr_q;
					rdata_q[`USBRRC_STS_HALTED] <= sched_halted;
				end
				`USBRRC_PORT0_OFS: begin
					rdata_q <= port_word[0];
				end
				`USBRRC_PORT1_OFS: begin
					rdata_q <= port_word[1];
				end
				default: begin
					rdata_q <= 16'h0000;
				end
			endcase
		end
	end

	assign io_rdata_o = rdata_q;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	sequence srst_request_s;
		wr_cmd && io_wdata_i[`USBRRC_CMD_SRST] && !srst_q && !hw_rst;
	endsequence

	sequence srst_done_s;
		srst_q [*4] ##1 !srst_q;
	endsequence

	bus_reset_follow_a: assert property ((wr_cmd && io_wdata_i[`USBRRC_CMD_GRST])
		|=> bus_reset_o)
		else $error("bus reset not driven after bit set");
	bus_reset_end_a: assert property ((wr_cmd && !io_wdata_i[`USBRRC_CMD_GRST])
		|=> !bus_reset_o)
		else $error("bus reset still driven after bit cleared");
	hw_reset_quiet_a: assert property (@(posedge ref_clk_i) disable iff (1'b0)
		rst_i |-> !bus_reset_o)
		else $error("bus reset driven during chip reset");
	grst_clears_run_a: assert property (grst_q |=> (!run_q && !srst_q))
		else $error("bus-wide reset did not clear logic");
	soft_self_clear_a: assert property (srst_request_s |=> srst_done_s)
		else $error("soft reset bit did not self clear in time");
	soft_clears_run_a: assert property (srst_q |=> !run_q && !sched_busy)
		else $error("soft reset left engine running");
	abort_on_soft_a: assert property ((srst_q && sched_busy) |-> txn_abort_o)
		else $error("transaction not aborted on soft reset");
	fatal_stop_a: assert property ((fatal && !logic_rst) |=> !run_q)
		else $error("run bit survived fatal error");
	halt_bound_a: assert property ((!run_q && !sched_busy && !logic_rst)
		|-> ##[0:2] sched_halted)
		else $error("halted flag late after stop");
	run_starts_a: assert property ((run_q && !sched_busy && !fatal && !logic_rst
		&& !(wr_cmd && !io_wdata_i[`USBRRC_CMD_RUN])) |-> ##[0:1] txn_start_o)
		else $error("running engine failed to start a transaction");

endmodule

// file: testbench/usbrrc_dev_model.sv
// Far-side model: attached bus devices and a transaction responder
`timescale 1ns/1ps
module usbrrc_dev_model (
	input wire logic ref_clk_i,
	input wire logic txn_start_i,
	input wire logic txn_abort_i,
	input wire logic [7:0] delay_i,
	input wire logic [1:0] attach_i,
	input wire logic [1:0] slow_dev_i,
	output logic [1:0] present_o,
	output logic [1:0] low_speed_o,
	output logic txn_done_o
);
	logic [7:0] cnt_q;
	assign present_o = attach_i;
	// Detached port: speed sense falls to its pull-down
	assign low_speed_o = attach_i & slow_dev_i;
	initial begin
		cnt_q = 8'h00;
		txn_done_o = 1'b0;
	end
	always @(posedge ref_clk_i) begin
		txn_done_o <= 1'b0;
		if (txn_abort_i) begin
			cnt_q <= 8'h00;
		end else if (txn_start_i) begin
			cnt_q <= delay_i;
		end else if (cnt_q == 8'h01) begin
			cnt_q <= 8'h00;
			txn_done_o <= 1'b1;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
endmodule

// file: testbench/tb.sv
// Register-level bench for host reset and run control
`timescale 1ns/1ps
`include "usbrrc_regs.svh"
module tb;
	logic ref_clk_i, rst_i, io_wr_i, io_rd_i, fat_c, fat_b, done;
	logic [4:0] io_addr_i;
	logic [15:0] io_wdata_i, io_rdata_o, rd;
	logic bus_reset_o, txn_start_o, txn_abort_o, abort_seen;
	logic [1:0] pres, ls, p_conn, p_en, p_rst;
	logic [7:0] delay;
	int err_total, num_checks, cyc, starts, s0;
	usbrrc_top u_usbrrc_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .io_wr_i(io_wr_i),
		.io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
		.io_rdata_o(io_rdata_o), .bus_reset_o(bus_reset_o), .txn_start_o(txn_start_o),
		.txn_abort_o(txn_abort_o), .txn_done_i(done), .fatal_consist_i(fat_c),
		.fatal_bus_err_i(fat_b), .dev_present_i(pres), .dev_low_speed_i(ls),
		.port_connect_o(p_conn), .port_enable_o(p_en), .port_reset_o(p_rst));
	usbrrc_dev_model u_usbrrc_dev_model (.ref_clk_i(ref_clk_i), .txn_start_i(txn_start_o),
		.txn_abort_i(txn_abort_o), .delay_i(delay), .attach_i(2'h3), .slow_dev_i(2'h2),
		.present_o(pres), .low_speed_o(ls), .txn_done_o(done));
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (txn_start_o === 1'b1) starts <= starts + 1;
		if (txn_abort_o === 1'b1) abort_seen <= 1'b1;
		if (cyc == 30000) begin
			err_total = err_total + 1;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge ref_clk_i);
		io_wr_i = 1'b1;
		io_addr_i = a;
		io_wdata_i = d;
		@(negedge ref_clk_i);
		io_wr_i = 1'b0;
	endtask
	task automatic rdr(input logic [4:0] a);
		@(negedge ref_clk_i);
		io_rd_i = 1'b1;
		io_addr_i = a;
		@(negedge ref_clk_i);
		io_rd_i = 1'b0;
		rd = io_rdata_o;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	task automatic wait_start();
		int k;
		k = starts;
		for (int i = 0; i < 200 && starts == k; i++) @(negedge ref_clk_i);
	endtask
	initial begin
		{io_wr_i, io_rd_i, fat_c, fat_b, abort_seen} = 5'h00;
		io_addr_i = 5'h00;
		io_wdata_i = 16'h0000;
		delay = 8'h02;
		{err_total, num_checks, cyc, starts} = '0;
		rst_i = 1'b1;
		idle(12);
		chk({15'h0000, bus_reset_o}, 16'h0000);
		rst_i = 1'b0;
		rdr(`USBRRC_CMD_OFS);
		chk(rd, 16'h0000);
		rdr(`USBRRC_STS_OFS);
		chk(rd, 16'h0020);
		rdr(5'h08);
		chk(rd, 16'h0000);
		idle(1400);
		rdr(`USBRRC_PORT0_OFS);
		chk(rd & 16'h0101, 16'h0001);
		rdr(`USBRRC_PORT1_OFS);
		chk(rd & 16'h0101, 16'h0101);
		// Run with a quick responder: back-to-back transactions
		wr(`USBRRC_CMD_OFS, 16'h0001);
		idle(30);
		chk({15'h0000, starts > 4}, 16'h0001);
		rdr(`USBRRC_STS_OFS);
		chk(rd, 16'h0000);
		// Stop while a slow transaction is underway
		delay = 8'h28;
		wait_start();
		s0 = starts;
		wr(`USBRRC_CMD_OFS, 16'h0000);
		rdr(`USBRRC_STS_OFS);
		chk(rd, 16'h0000);
		idle(50);
		rdr(`USBRRC_STS_OFS);
		chk(rd, 16'h0020);
		chk(starts[15:0], s0[15:0]);
		// Fatal errors clear run; flags are write-one-to-clear
		delay = 8'h03;
		wr(`USBRRC_CMD_OFS, 16'h0001);
		idle(10);
		@(negedge ref_clk_i);
		fat_c = 1'b1;
		@(negedge ref_clk_i);
		fat_c = 1'b0;
		rdr(`USBRRC_CMD_OFS);
		chk(rd, 16'h0000);
		idle(10);
		rdr(`USBRRC_STS_OFS);
		chk(rd, 16'h0030);
		wr(`USBRRC_STS_OFS, 16'h0010);
		wr(`USBRRC_CMD_OFS, 16'h0001);
		idle(10);
		@(negedge ref_clk_i);
		fat_b = 1'b1;
		@(negedge ref_clk_i);
		fat_b = 1'b0;
		idle(10);
		rdr(`USBRRC_STS_OFS);
		chk(rd, 16'h0028);
		wr(`USBRRC_STS_OFS, 16'h0008);
		// Soft reset during a slow transaction
		wr(`USBRRC_PORT0_OFS, 16'h0206);
		wr(`USBRRC_PORT0_OFS, 16'h020E);
		rdr(`USBRRC_PORT0_OFS);
		chk(rd, 16'h0205);
		chk({12'h000, p_rst, p_en}, 16'h0005);
		delay = 8'h40;
		wr(`USBRRC_CMD_OFS, 16'h0001);
		wait_start();
		wr(`USBRRC_CMD_OFS, 16'h0002);
		rdr(`USBRRC_CMD_OFS);
		chk(rd, 16'h0002);
		chk({15'h0000, abort_seen}, 16'h0001);
		rdr(`USBRRC_PORT0_OFS);
		chk(rd, 16'h020A);
		chk({14'h0000, p_conn}, 16'h0000);
		chk({12'h000, p_rst, p_en}, 16'h0004);
		idle(4);
		rdr(`USBRRC_CMD_OFS);
		chk(rd, 16'h0000);
		rdr(`USBRRC_STS_OFS);
		chk(rd, 16'h0020);
		idle(1400);
		rdr(`USBRRC_PORT1_OFS);
		chk(rd & 16'h0101, 16'h0101);
		// Bus-wide reset: signalling while set, hub registers to power-on
		// Hold shortened far below ten milliseconds to keep the run short
		wr(`USBRRC_CMD_OFS, 16'h0004);
		idle(2);
		chk({15'h0000, bus_reset_o}, 16'h0001);
		rdr(`USBRRC_PORT0_OFS);
		chk(rd, 16'h0000);
		wr(`USBRRC_CMD_OFS, 16'h0000);
		idle(1);
		chk({15'h0000, bus_reset_o}, 16'h0000);
		wr(`USBRRC_CMD_OFS, 16'h0004);
		@(negedge ref_clk_i);
		rst_i = 1'b1;
		idle(2);
		chk({15'h0000, bus_reset_o}, 16'h0000);
		rst_i = 1'b0;
		rdr(`USBRRC_CMD_OFS);
		chk(rd, 16'h0000);
		give_verdict();
	end
endmodule
